/* File: src/tap_pkg.sv */
// Constants shared by the SRAM boundary-scan test port.
// Assumes a single system clock that oversamples the test clock pin.
package tap_pkg;
  // ----------------------------------------
  // Instruction codes
  // ----------------------------------------
  localparam int IR_WIDTH = 3;
  localparam logic [2:0] INS_EXTEST = 3'h0;
  localparam logic [2:0] INS_IDENT = 3'h1;
  localparam logic [2:0] INS_SAMPLE_Z = 3'h2;
  localparam logic [2:0] INS_SAMPLE_PRELOAD = 3'h4;
  localparam logic [2:0] INS_BYPASS = 3'h7;
  localparam logic [1:0] IR_CAPTURE_PATTERN = 2'h1;
  // ----------------------------------------
  // Register sizes and reset values
  // ----------------------------------------
  localparam int ID_WIDTH = 32;
  localparam int BSR_LENGTH = 109;
  localparam int OE_CELL = 108;
  localparam int RESET_TMS_EDGES = 5;
  localparam int SYNC_STAGES = 3;
  // Arbitrary neutral identification value
  localparam logic [31:0] ID_CODE_DEFAULT = 32'h0000_0001;
  // ----------------------------------------
  // Controller states
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR,
    ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
    ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } tap_state_t;
endpackage : tap_pkg

/* File: src/pin_sync.sv */
// Three-stage synchroniser for one pin input.
// Assumes the pin is asynchronous to clk_in; agreement of stages two and three counts.
`timescale 1ns/10ps
module pin_sync
  import tap_pkg::*;
#(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic pin_in,
  output logic level_out
);
  logic [SYNC_STAGES-1:0] stage_q;
  // ----------------------------------------
  // Sampling chain
  // ----------------------------------------
  // Stage one is only read by stage two
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage_q <= {SYNC_STAGES{RESET_VAL}};
      level_out <= RESET_VAL;
    end else begin
      stage_q <= {stage_q[SYNC_STAGES-2:0], pin_in};
      if (stage_q[1] == stage_q[2]) begin
        level_out <= stage_q[2];
      end
    end
  end
endmodule : pin_sync

/* File: src/tap_fsm.sv */
// Sixteen-state test-port controller.
// Assumes tck_rise_in is a one-cycle pulse per test clock rising edge.
`timescale 1ns/10ps
module tap_fsm
  import tap_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic tck_rise_in,
  input wire logic tms_in,
  output tap_state_t state_out
);
  tap_state_t state_d;
  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Five high TMS edges reach reset from any state
  always_comb begin
    state_d = state_out;
    case (state_out)
      ST_RESET: state_d = tms_in ? ST_RESET : ST_IDLE;
      ST_IDLE: state_d = tms_in ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: state_d = tms_in ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: state_d = tms_in ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: state_d = tms_in ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: state_d = tms_in ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: state_d = tms_in ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: state_d = tms_in ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR: state_d = tms_in ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: state_d = tms_in ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: state_d = tms_in ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: state_d = tms_in ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: state_d = tms_in ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: state_d = tms_in ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: state_d = tms_in ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR: state_d = tms_in ? ST_SEL_DR : ST_IDLE;
      default: state_d = ST_RESET;
    endcase
  end

  // State register, advanced only on test clock rises
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_out <= ST_RESET;
    end else if (tck_rise_in) begin
      state_out <= state_d;
    end
  end
endmodule : tap_fsm

/* File: src/sram_boundary_scan_tap.sv */
// Boundary-scan test access port of a burst SRAM: controller, instruction,
// bypass, identification and boundary registers, serial output.
// Assumes the test clock is far slower than ref_clk_in and is sampled as a pin.
`timescale 1ns/10ps
module sram_boundary_scan_tap
  import tap_pkg::*;
#(
  parameter int BSR_LEN = BSR_LENGTH,
  parameter logic [ID_WIDTH-1:0] ID_CODE = ID_CODE_DEFAULT
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tms_drive_in,
  input wire logic tdi_in,
  input wire logic tdi_drive_in,
  input wire logic [BSR_LEN-1:0] pin_ring_in,
  input wire logic [BSR_LEN-1:0] core_out_in,
  input wire logic core_oe_in,
  output logic tdo_out,
  output logic tdo_oe_out,
  output logic [BSR_LEN-1:0] pin_drive_out,
  output logic pin_oe_out,
  output logic [IR_WIDTH-1:0] instr_out
);
  // ----------------------------------------
  // Reset release and pin sampling
  // ----------------------------------------
  logic rst_sync1_q;
  logic rst_sync2_q;
  logic rst_n;
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic tck_prev_q;
  logic tck_rise;
  logic tck_fall;
  logic tms_pin;
  logic tdi_pin;
  tap_state_t state;

  // Reset released through two flops; asserted immediately. Everything below
  // uses the released copy so no flop leaves reset a cycle before its peers
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync1_q <= 1'b0;
      rst_sync2_q <= 1'b0;
    end else begin
      rst_sync1_q <= 1'b1;
      rst_sync2_q <= rst_sync1_q;
    end
  end
  assign rst_n = rst_sync2_q;

  // Internal pull-ups: an undriven pin reads high
  assign tms_pin = tms_drive_in ? tms_in : 1'b1;
  assign tdi_pin = tdi_drive_in ? tdi_in : 1'b1;

  // Each pin crosses through four flops. Mode-select and serial input see
  // the same delay as the test clock, so their relation to its edges holds;
  // the clock resets low and the data pins high, matching their idle levels
  pin_sync #(.RESET_VAL(1'b0)) u_sync_tck (
    .clk_in(ref_clk_in),
    .rst_n_in(rst_n),
    .pin_in(tck_in),
    .level_out(tck_s)
  );

  pin_sync #(.RESET_VAL(1'b1)) u_sync_tms (
    .clk_in(ref_clk_in),
    .rst_n_in(rst_n),
    .pin_in(tms_pin),
    .level_out(tms_s)
  );

  pin_sync #(.RESET_VAL(1'b1)) u_sync_tdi (
    .clk_in(ref_clk_in),
    .rst_n_in(rst_n),
    .pin_in(tdi_pin),
    .level_out(tdi_s)
  );

  // Edge finder on the filtered test clock; a test clock held low never
  // produces an edge, so everything but the pin path stays frozen
  // Resetting the history low matches the idle pin, so no false edge follows
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      tck_prev_q <= 1'b0;
    end else begin
      tck_prev_q <= tck_s;
    end
  end
  assign tck_rise = tck_s & ~tck_prev_q;
  assign tck_fall = ~tck_s & tck_prev_q;

  // ----------------------------------------
  // Controller
  // ----------------------------------------
  tap_fsm u_fsm (
    .clk_in(ref_clk_in),
    .rst_n_in(rst_n),
    .tck_rise_in(tck_rise),
    .tms_in(tms_s),
    .state_out(state)
  );

  // ----------------------------------------
  // State and instruction decode
  // ----------------------------------------
  logic [IR_WIDTH-1:0] ir_shift_q;
  logic [IR_WIDTH-1:0] ir_shift_d;
  logic [IR_WIDTH-1:0] ir_q;
  logic st_reset;
  logic st_cap_dr;
  logic st_shift_dr;
  logic st_upd_dr;
  logic st_cap_ir;
  logic st_shift_ir;
  logic st_upd_ir;
  logic sel_bsr;
  logic sel_id;
  logic sel_byp;
  logic is_extest;
  logic is_sample_z;

  // State flags used by the register and output logic
  assign st_reset = (state == ST_RESET);
  assign st_cap_dr = (state == ST_CAP_DR);
  assign st_shift_dr = (state == ST_SHIFT_DR);
  assign st_upd_dr = (state == ST_UPD_DR);
  assign st_cap_ir = (state == ST_CAP_IR);
  assign st_shift_ir = (state == ST_SHIFT_IR);
  assign st_upd_ir = (state == ST_UPD_IR);

  // One-hot register select; reserved codes fall through to bypass
  // so a stray code can never reach the boundary or identification path
  assign is_extest = (ir_q == INS_EXTEST);
  assign is_sample_z = (ir_q == INS_SAMPLE_Z);
  assign sel_bsr = is_extest | is_sample_z | (ir_q == INS_SAMPLE_PRELOAD);
  assign sel_id = (ir_q == INS_IDENT);
  assign sel_byp = ~sel_bsr & ~sel_id;

  // ----------------------------------------
  // Instruction register
  // ----------------------------------------
  // Shift stage: capture pattern, then shift top-in, bottom-out
  // The top bit keeps its old value at capture; only the low two are fixed
  always_comb begin
    ir_shift_d = ir_shift_q;
    if (st_reset) begin
      ir_shift_d = INS_IDENT;
    end else if (st_cap_ir) begin
      ir_shift_d = {ir_shift_q[IR_WIDTH-1:2], IR_CAPTURE_PATTERN};
    end else if (st_shift_ir) begin
      ir_shift_d = {tdi_s, ir_shift_q[IR_WIDTH-1:1]};
    end
  end

  // Shift stage loads on test clock rises; in reset it is held at the
  // identification code so a later update cannot pick up stale bits
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ir_shift_q <= INS_IDENT;
    end else if (st_reset) begin
      ir_shift_q <= INS_IDENT;
    end else if (tck_rise) begin
      ir_shift_q <= ir_shift_d;
    end
  end

  // The active instruction changes only at update or reset. Reset is
  // applied in the first system cycle of the reset state rather than at
  // the next test clock rise, since the clock may stop right there
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ir_q <= INS_IDENT;
    end else if (st_reset) begin
      ir_q <= INS_IDENT;
    end else if (tck_rise && st_upd_ir) begin
      ir_q <= ir_shift_q;
    end
  end

  // ----------------------------------------
  // Data registers
  // ----------------------------------------
  logic byp_q;
  logic [ID_WIDTH-1:0] id_q;
  logic [BSR_LEN-1:0] bsr_q;
  logic [BSR_LEN-1:0] bsr_d;
  logic [BSR_LEN-1:0] preload_q;
  logic [ID_WIDTH-1:0] id_d;
  logic byp_d;
  logic [BSR_LEN-1:0] preload_reset;

  assign preload_reset = {{(BSR_LEN-OE_CELL){1'b1}}, {OE_CELL{1'b0}}};

  // Bypass clears on capture, then passes data with one stage of delay
  assign byp_d = st_cap_dr ? 1'b0 : (st_shift_dr ? tdi_s : byp_q);
  // The identification code is a parameter, fixed for the built part
  assign id_d = st_cap_dr ? ID_CODE : (st_shift_dr ? {tdi_s, id_q[ID_WIDTH-1:1]} : id_q);
  // Full ring snapshot, one cell per ball including unconnected ones
  assign bsr_d = st_cap_dr ? pin_ring_in : (st_shift_dr ? {tdi_s, bsr_q[BSR_LEN-1:1]} : bsr_q);

  // Each register moves only while selected so others keep their contents;
  // a deselected register therefore still shows its last capture later

  // Bypass stage
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      byp_q <= 1'b0;
    end else if (tck_rise && sel_byp) begin
      byp_q <= byp_d;
    end
  end

  // Identification register; the reset value is the same hardwired code
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      id_q <= ID_CODE;
    end else if (tck_rise && sel_id) begin
      id_q <= id_d;
    end
  end

  // Boundary shift stage
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      bsr_q <= '0;
    end else if (tck_rise && sel_bsr) begin
      bsr_q <= bsr_d;
    end
  end

  // Preload latch: output-enable cell preset at power-up and throughout the
  // reset state, so external test starts with the data drivers enabled
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      preload_q <= {{(BSR_LEN-OE_CELL){1'b1}}, {OE_CELL{1'b0}}};
    end else if (st_reset) begin
      preload_q <= preload_reset;
    end else if (tck_rise && sel_bsr && st_upd_dr) begin
      preload_q <= bsr_q;
    end
  end

  // ----------------------------------------
  // Serial output and pin control
  // ----------------------------------------
  logic tdo_d;
  logic tdo_oe_d;
  logic [BSR_LEN-1:0] pin_drive_d;
  logic pin_oe_d;
  logic preload_seen_q;

  // Bit zero of the selected register, or of the instruction stage
  // Only bit zero ever reaches the pin, so the wide registers need no mux
  assign tdo_d = st_shift_ir ? ir_shift_q[0] :
                 sel_bsr ? bsr_q[0] : (sel_id ? id_q[0] : byp_q);
  assign tdo_oe_d = st_shift_ir | st_shift_dr;

  // Test only overrides the memory under extest and sample-high-Z; otherwise
  // the core path passes untouched, so a port reset never disturbs the memory
  assign pin_drive_d = is_extest ? preload_q : core_out_in;
  assign pin_oe_d = is_sample_z ? 1'b0 : (is_extest ? preload_q[OE_CELL] : core_oe_in);

  // Marks the first cycle after reset; see the output enable below
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      preload_seen_q <= 1'b0;
    end else begin
      preload_seen_q <= 1'b1;
    end
  end

  // Serial output updates on the falling edge, released at power-up
  // Updating on the fall gives the far controller half a test clock of
  // setup before it samples at the next rise
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      tdo_out <= 1'b1;
      tdo_oe_out <= 1'b0;
    end else if (tck_fall) begin
      tdo_out <= tdo_d;
      tdo_oe_out <= tdo_oe_d;
    end
  end

  // Pin path follows the core every cycle, since memory runs at full speed;
  // the test clock never gates it, so a port reset cannot stall the memory
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pin_drive_out <= '0;
    end else begin
      pin_drive_out <= pin_drive_d;
    end
  end

  // Output enable stays off for the first cycle out of reset, before the
  // core enable has been sampled once
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pin_oe_out <= 1'b0;
    end else begin
      pin_oe_out <= preload_seen_q & pin_oe_d;
    end
  end

  // Copy of the active instruction for the memory's mode logic
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      instr_out <= INS_IDENT;
    end else begin
      instr_out <= ir_q;
    end
  end
endmodule : sram_boundary_scan_tap

/* File: sim/tap_properties.sv */
// Concurrent checks on the boundary-scan test port pins.
// Assumes the test clock idles low between frames.
`timescale 1ns/10ps
module tap_properties
  import tap_pkg::*;
#(
  parameter int BSR_LEN = BSR_LENGTH
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tms_drive_in,
  input wire logic tdi_in,
  input wire logic tdi_drive_in,
  input wire logic [BSR_LEN-1:0] pin_ring_in,
  input wire logic [BSR_LEN-1:0] core_out_in,
  input wire logic core_oe_in,
  input wire logic tdo_out,
  input wire logic tdo_oe_out,
  input wire logic [BSR_LEN-1:0] pin_drive_out,
  input wire logic pin_oe_out,
  input wire logic [IR_WIDTH-1:0] instr_out
);
  // ----------------------------------------
  // Test clock tracking
  // ----------------------------------------
  logic tck_q;
  logic tck_rise;
  logic tms_seen;
  logic [2:0] high_q;
  logic [2:0] high_d;
  logic [3:0] quiet_q;
  logic [3:0] quiet_d;
  // Raw pin sampling runs ahead of the design's synchroniser, hence slack below
  assign tms_seen = tms_drive_in ? tms_in : 1'b1;
  assign tck_rise = tck_in && !tck_q;
  assign high_d = !tck_rise ? high_q : !tms_seen ? 3'h0 : (high_q == 3'h4) ? 3'h4 : high_q + 3'h1;
  assign quiet_d = (tck_in != tck_q) ? 4'h0 : (quiet_q == 4'hF) ? 4'hF : quiet_q + 4'h1;
  // Edge history, mode-select run length, idle time
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tck_q <= 1'b0;
      high_q <= 3'h0;
      quiet_q <= 4'hF;
    end else begin
      tck_q <= tck_in;
      high_q <= high_d;
      quiet_q <= quiet_d;
    end
  end
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence s_fifth_high;
    tck_rise && tms_seen && high_q == 3'h4;
  endsequence
  sequence s_port_reset;
    ##[1:12] (instr_out == INS_IDENT && !tdo_oe_out);
  endsequence
  AST_TDO_AT_FALL: assert property ((($changed(tdo_out) && tdo_oe_out) || $changed(tdo_oe_out)) |-> !tck_in)
    else $error("serial output moved while test clock high");
  AST_TDO_HOLD: assert property ($rose(tck_in) && tdo_oe_out |=> ($stable(tdo_out) && $stable(tdo_oe_out))[*4])
    else $error("serial output not held after test clock rise");
  AST_INSTR_QUIET: assert property ($changed(instr_out) |-> quiet_q < 4'hC)
    else $error("instruction changed with test clock idle");
  AST_RESET_STATE: assert property ($rose(rst_n_in) |-> instr_out == INS_IDENT && !tdo_oe_out)
    else $error("wrong state at reset release");
  AST_SAMPLE_Z_OFF: assert property ((instr_out == INS_SAMPLE_Z)[*3] |-> !pin_oe_out)
    else $error("outputs enabled under sample high-z");
  AST_EXTEST_CELL: assert property ((instr_out == INS_EXTEST)[*3] |-> pin_oe_out == pin_drive_out[OE_CELL])
    else $error("output enable differs from cell 108");
  AST_NORMAL_PATH: assert property ((instr_out != INS_EXTEST && instr_out != INS_SAMPLE_Z)[*4] |->
      pin_drive_out == $past(core_out_in) && pin_oe_out == $past(core_oe_in))
    else $error("memory outputs disturbed by test port");
  AST_TMS_RESET: assert property (s_fifth_high |-> s_port_reset)
    else $error("no reset after five high mode-select edges");
endmodule : tap_properties

bind sram_boundary_scan_tap tap_properties #(
  .BSR_LEN(BSR_LEN)
) i_props (
  .ref_clk_in(ref_clk_in),
  .rst_n_in(rst_n_in),
  .tck_in(tck_in),
  .tms_in(tms_in),
  .tms_drive_in(tms_drive_in),
  .tdi_in(tdi_in),
  .tdi_drive_in(tdi_drive_in),
  .pin_ring_in(pin_ring_in),
  .core_out_in(core_out_in),
  .core_oe_in(core_oe_in),
  .tdo_out(tdo_out),
  .tdo_oe_out(tdo_oe_out),
  .pin_drive_out(pin_drive_out),
  .pin_oe_out(pin_oe_out),
  .instr_out(instr_out)
);

/* File: sim/jtag_ctrl_model.sv */
// Behavioural external scan controller driving the test pins.
// Assumes the caller starts each scan from the idle state.
`timescale 1ns/10ps
module jtag_ctrl_model (
  output logic tck_out,
  output logic tms_out,
  output logic tms_drive_out,
  output logic tdi_out,
  output logic tdi_drive_out,
  input wire logic tdo_in,
  input wire logic tdo_oe_in
);
  // Test clock rests low outside frames
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tms_drive_out = 1'b1;
    tdi_out = 1'b1;
    tdi_drive_out = 1'b1;
  end
  // One 125 ns period; pins change at the fall, tdo read just before the rise
  task automatic step(input logic m, input logic d, output logic o);
    tms_out <= m;
    tdi_out <= d;
    #62.5;
    o = tdo_oe_in ? tdo_in : 1'bx;
    tck_out <= 1'b1;
    #62.5;
    tck_out <= 1'b0;
  endtask : step
  // Full scan from idle back to idle, bit zero first
  task automatic scan(input logic ir, input int n, input logic [127:0] din, output logic [127:0] dout);
    logic o;
    dout = '0;
    step(1'b1, 1'b1, o);
    if (ir) step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
    step(1'b0, 1'b1, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
  endtask : scan
  // Released pins show the pull-up level, not the low value still driven
  task automatic float_walk(input int n);
    logic o;
    tms_drive_out <= 1'b0;
    tdi_drive_out <= 1'b0;
    repeat (n) step(1'b0, 1'b0, o);
    tms_drive_out <= 1'b1;
    tdi_drive_out <= 1'b1;
  endtask : float_walk
endmodule : jtag_ctrl_model

/* File: sim/test_sram_boundary_scan_tap.sv */
// Self-checking bench for the boundary-scan test port.
// Assumes the partner model owns the test pins.
`timescale 1ns/10ps
module test_sram_boundary_scan_tap;
  import tap_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic tck, tms, tms_drv, tdi, tdi_drv, tdo, tdo_oe, pin_oe, o;
  logic core_oe = 1'b0;
  logic [BSR_LENGTH-1:0] pin_ring = '0, core_out = '0, pin_drive;
  logic [IR_WIDTH-1:0] instr, code;
  logic [127:0] rd, nxt;
  logic [127:0] pre = '0;
  logic [2:0] codes [8] = '{3'h4, 3'h0, 3'h2, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
  int fail_count = 0;
  int cmp_count = 0;
  always #5 ref_clk = ~ref_clk;
  jtag_ctrl_model i_ctrl (.tck_out(tck), .tms_out(tms), .tms_drive_out(tms_drv), .tdi_out(tdi),
    .tdi_drive_out(tdi_drv), .tdo_in(tdo), .tdo_oe_in(tdo_oe));
  sram_boundary_scan_tap i_dut (.ref_clk_in(ref_clk), .rst_n_in(rst_n), .tck_in(tck), .tms_in(tms),
    .tms_drive_in(tms_drv), .tdi_in(tdi), .tdi_drive_in(tdi_drv), .pin_ring_in(pin_ring),
    .core_out_in(core_out), .core_oe_in(core_oe), .tdo_out(tdo), .tdo_oe_out(tdo_oe),
    .pin_drive_out(pin_drive), .pin_oe_out(pin_oe), .instr_out(instr));
  // ----------------------------------------
  // Expectations and reporting
  // ----------------------------------------
  function automatic logic [127:0] rnd();
    return {$urandom(), $urandom(), $urandom(), $urandom()};
  endfunction : rnd
  function automatic logic [127:0] exp_pins(input logic [2:0] c, input logic oe);
    if (c == INS_EXTEST) return oe ? 128'(pre[OE_CELL]) : pre;
    if (oe) return (c == INS_SAMPLE_Z) ? '0 : 128'(core_oe);
    return 128'(core_out);
  endfunction : exp_pins
  // Captured value followed by the tdi stream, seen through the register length
  function automatic logic [127:0] exp_dr(input logic [2:0] c, input logic [127:0] d);
    int n;
    n = (c == INS_IDENT) ? ID_WIDTH : (c == INS_EXTEST || c == INS_SAMPLE_Z || c == INS_SAMPLE_PRELOAD) ? BSR_LENGTH : 1;
    return 128'(BSR_LENGTH'((d << n) | (n == 1 ? '0 : n == ID_WIDTH ? 128'(ID_CODE_DEFAULT) : 128'(pin_ring))));
  endfunction : exp_dr
  task automatic check(input string what, input logic [127:0] exp, input logic [127:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize
  // Main sequence: every code, pin capture, preload, forced resets
  initial begin
    void'($urandom(64871));
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check("instr reset", 128'(INS_IDENT), 128'(instr));
    check("tdo_oe reset", '0, 128'(tdo_oe));
    repeat (5) i_ctrl.step(1'b1, 1'b1, o);
    i_ctrl.step(1'b0, 1'b1, o);
    foreach (codes[k]) begin
      @(posedge ref_clk);
      pin_ring <= BSR_LENGTH'(rnd());
      core_out <= BSR_LENGTH'(rnd());
      core_oe <= 1'($urandom());
      code = codes[k];
      i_ctrl.scan(1'b1, IR_WIDTH, 128'(code), rd);
      check("ir capture", 128'(IR_CAPTURE_PATTERN), 128'(rd[1:0]));
      check("instr", 128'(code), 128'(instr));
      check("pin oe", exp_pins(code, 1'b1), 128'(pin_oe));
      check("pin drive", exp_pins(code, 1'b0), 128'(pin_drive));
      nxt = rnd();
      nxt[OE_CELL] = (k == 0);
      i_ctrl.scan(1'b0, BSR_LENGTH, nxt, rd);
      check("dr out", exp_dr(code, nxt), rd);
      check("instr hold", 128'(code), 128'(instr));
      if (exp_dr(code, nxt) == 128'(pin_ring)) pre = 128'(BSR_LENGTH'(nxt));
      check("pin oe upd", exp_pins(code, 1'b1), 128'(pin_oe));
      check("pin drive upd", exp_pins(code, 1'b0), 128'(pin_drive));
    end
    i_ctrl.step(1'b1, 1'b1, o);
    i_ctrl.step(1'b0, 1'b1, o);
    i_ctrl.step(1'b0, 1'b1, o);
    i_ctrl.step(1'b0, 1'b1, o);
    check("bypass first bit", '0, 128'(o));
    repeat (5) i_ctrl.step(1'b1, 1'b1, o);
    repeat (4) @(posedge ref_clk);
    check("instr tms reset", 128'(INS_IDENT), 128'(instr));
    check("tdo_oe tms reset", '0, 128'(tdo_oe));
    i_ctrl.step(1'b0, 1'b1, o);
    i_ctrl.scan(1'b1, IR_WIDTH, 128'(INS_BYPASS), rd);
    i_ctrl.float_walk(5);
    repeat (4) @(posedge ref_clk);
    check("instr pulled up", 128'(INS_IDENT), 128'(instr));
    summarize();
  end
  // Watchdog bounds the whole run
  initial begin
    for (int w = 0; w < 90000; w++) @(posedge ref_clk);
    fail_count++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    summarize();
  end
endmodule : test_sram_boundary_scan_tap
